// file: src/crtc_timing_pkg.sv
package crtc_timing_pkg;
  // register indices on the indexed data port
  localparam logic [7:0] IDX_HSYNC_START  = 8'h04;
  localparam logic [7:0] IDX_HSYNC_END    = 8'h05;
  localparam logic [7:0] IDX_VTOTAL       = 8'h06;
  localparam logic [7:0] IDX_OVERFLOW     = 8'h07;
  localparam logic [7:0] IDX_ROW_SCAN_PAN = 8'h08;
  // field positions in the sync end register
  localparam int HEND_LSB      = 0;
  localparam int HDLY_LSB      = 5;
  localparam int HBEND5_BIT    = 7;
  // overflow register bit positions
  localparam int OV_VT8        = 0;
  localparam int OV_VDE8       = 1;
  localparam int OV_VSS8       = 2;
  localparam int OV_VBS8       = 3;
  localparam int OV_LC8        = 4;
  localparam int OV_VT9        = 5;
  localparam int OV_VDE9       = 6;
  localparam int OV_VSS9       = 7;
  // row scan and pan register fields
  localparam int PAN_LSB       = 5;
  localparam logic [7:0] ROW_SCAN_PAN_MASK = 8'h7f;
  // reset values
  localparam logic [7:0] RST_HSYNC_START  = 8'h00;
  localparam logic [7:0] RST_HSYNC_END    = 8'h00;
  localparam logic [7:0] RST_VTOTAL       = 8'h00;
  localparam logic [7:0] RST_OVERFLOW     = 8'h00;
  localparam logic [7:0] RST_ROW_SCAN_PAN = 8'h00;
  // pixels per byte of coarse pan
  localparam int PIX_PER_BYTE  = 8;
endpackage

// file: src/crtc_hsync_vtotal_timing.sv
// Function
// - hsync goes active when character counter equals sync start value.
// - delay field postpones external hsync by zero to three character clocks.
// - low five counter bits matching sync end field end the sync pulse.
// - sync end register bit 7 is blanking end bit 5.
// - vertical total is 10 bits from total register and overflow bits 0, 5.
// - vertical retrace begins when scanline counter equals vertical total.
// - vertical sync start compare uses overflow bits 2 and 7 as bits 8, 9.
// - vertical display end uses overflow bits 1 and 6 as bits 8, 9.
// - overflow bit 3 is vertical blanking start bit 8; cell height gives bit 9.
// - overflow bit 4 is line compare bit 8; cell height gives bit 9.
// - line compare bit 8 is always writable, even when protected.
// - write protect blocks sync start, sync end, total and overflow writes.
// - coarse pan field shifts display start by 0 to 3 bytes.
// - preset row scan sets starting scanline of the first character row.
// - low six counter bits matching blanking end end blanking.
module crtc_hsync_vtotal_timing
  import crtc_timing_pkg::*;
#(
  parameter int CHAR_W = 8,
  parameter int LINE_W = 10
) (
  // character clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // indexed register port
  input  wire logic [7:0]        reg_index_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_write_in,
  output logic      [7:0]        reg_rdata_out,
  // fields owned by neighbouring registers
  input  wire logic [7:0]        horizontal_total_in,
  input  wire logic [4:0]        hblank_end_in,
  input  wire logic [1:0]        cell_height_ext_in,  // [0] vblank start 9, [1] line compare 9
  input  wire logic              timing_write_protect_in,
  input  wire logic              vretrace_end_in,
  // sync and timing outputs
  output logic                   hsync_out,
  output logic                   hblank_end_match_out,
  output logic                   vretrace_start_out,
  output logic [CHAR_W-1:0]      char_count_out,
  output logic [LINE_W-1:0]      scanline_count_out,
  // extended vertical fields for neighbouring comparators
  output logic [1:0]             vsync_start_hi_out,
  output logic [1:0]             vdisplay_end_hi_out,
  output logic [1:0]             vblank_start_hi_out,
  output logic [1:0]             line_compare_hi_out,
  // scroll settings
  output logic [1:0]             pan_bytes_out,
  output logic [4:0]             pan_pixels_out,
  output logic [4:0]             preset_row_scan_out
);

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_PULSE = 2'b01
  } hs_state_t;

  logic [7:0]        hsync_start_reg_ff;
  logic [7:0]        hsync_end_reg_ff;
  logic [7:0]        vertical_total_reg_ff;
  logic [7:0]        overflow_reg_ff;
  logic [7:0]        row_scan_pan_reg_ff;
  logic [CHAR_W-1:0] char_cnt_ff;
  logic [LINE_W-1:0] line_cnt_ff;
  logic              in_retrace_ff;
  hs_state_t         hs_state_ff;
  hs_state_t         nxt_hs_state;
  logic [3:0]        hs_pipe_ff;
  logic [9:0]        vtotal_full;
  logic              char_wrap;
  logic              hs_start_hit;
  logic              hs_end_hit;

  // shared write decode for the indexed port
  function automatic logic wr_hit(input logic [7:0] idx, input logic [7:0] want,
                                  input logic we);
    return we && (idx == want);
  endfunction

  // timing registers; protect leaves line compare bit 8 writable
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hsync_start_reg_ff    <= RST_HSYNC_START;
      hsync_end_reg_ff      <= RST_HSYNC_END;
      vertical_total_reg_ff <= RST_VTOTAL;
      overflow_reg_ff       <= RST_OVERFLOW;
      row_scan_pan_reg_ff   <= RST_ROW_SCAN_PAN;
    end else begin
      if (wr_hit(reg_index_in, IDX_HSYNC_START, reg_write_in) && !timing_write_protect_in) begin
        hsync_start_reg_ff <= reg_wdata_in;
      end
      if (wr_hit(reg_index_in, IDX_HSYNC_END, reg_write_in) && !timing_write_protect_in) begin
        hsync_end_reg_ff <= reg_wdata_in;
      end
      if (wr_hit(reg_index_in, IDX_VTOTAL, reg_write_in) && !timing_write_protect_in) begin
        vertical_total_reg_ff <= reg_wdata_in;
      end
      if (wr_hit(reg_index_in, IDX_OVERFLOW, reg_write_in)) begin
        if (timing_write_protect_in) begin
          overflow_reg_ff[OV_LC8] <= reg_wdata_in[OV_LC8];
        end else begin
          overflow_reg_ff <= reg_wdata_in;
        end
      end
      if (wr_hit(reg_index_in, IDX_ROW_SCAN_PAN, reg_write_in)) begin
        row_scan_pan_reg_ff <= reg_wdata_in & ROW_SCAN_PAN_MASK;  // reserved bit 7 stays zero
      end
    end
  end

  // read mux; unlisted indices read zero
  always_comb begin
    case (reg_index_in)
      IDX_HSYNC_START:  reg_rdata_out = hsync_start_reg_ff;
      IDX_HSYNC_END:    reg_rdata_out = hsync_end_reg_ff;
      IDX_VTOTAL:       reg_rdata_out = vertical_total_reg_ff;
      IDX_OVERFLOW:     reg_rdata_out = overflow_reg_ff;
      IDX_ROW_SCAN_PAN: reg_rdata_out = row_scan_pan_reg_ff;
      default:          reg_rdata_out = 8'h00;
    endcase
  end

  // ten-bit vertical total assembled from overflow bits
  assign vtotal_full = {overflow_reg_ff[OV_VT9], overflow_reg_ff[OV_VT8],
                        vertical_total_reg_ff};
  assign char_wrap   = (char_cnt_ff[7:0] == horizontal_total_in);

  // character counter wraps at the horizontal total
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      char_cnt_ff <= '0;
    end else if (char_wrap) begin
      char_cnt_ff <= '0;
    end else begin
      char_cnt_ff <= char_cnt_ff + 1'b1;
    end
  end

  // scanline counter steps per line; restarts when retrace ends
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      line_cnt_ff   <= '0;
      in_retrace_ff <= 1'b0;
    end else begin
      if (vretrace_end_in) begin
        line_cnt_ff   <= '0;
        in_retrace_ff <= 1'b0;
      end else begin
        if (char_wrap) begin
          line_cnt_ff <= line_cnt_ff + 1'b1;
        end
        if (line_cnt_ff == vtotal_full) begin
          in_retrace_ff <= 1'b1;
        end
      end
    end
  end

  // retrace start is a one-cycle pulse on first equality
  assign vretrace_start_out = (line_cnt_ff == vtotal_full) && !in_retrace_ff
                              && !vretrace_end_in;

  // comparators read live register contents every clock
  assign hs_start_hit = (char_cnt_ff[7:0] == hsync_start_reg_ff);
  assign hs_end_hit   = (char_cnt_ff[4:0] == hsync_end_reg_ff[4:0]);
  assign hblank_end_match_out =
    (char_cnt_ff[5:0] == {hsync_end_reg_ff[HBEND5_BIT], hblank_end_in});

  // internal sync state; end match checked only once the pulse is running
  always_comb begin
    nxt_hs_state = hs_state_ff;
    case (hs_state_ff)
      HS_IDLE:  if (hs_start_hit) nxt_hs_state = HS_PULSE;
      HS_PULSE: if (hs_end_hit) nxt_hs_state = HS_IDLE;
      default:  nxt_hs_state = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hs_state_ff <= HS_IDLE;
    end else begin
      hs_state_ff <= nxt_hs_state;
    end
  end

  // delay line for the external pulse; tap picked by the delay field
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hs_pipe_ff <= 4'h0;
    end else begin
      hs_pipe_ff <= {hs_pipe_ff[2:0], (nxt_hs_state == HS_PULSE)};
    end
  end

  assign hsync_out = hs_pipe_ff[hsync_end_reg_ff[HDLY_LSB +: 2]];

  // extension bits handed to neighbouring vertical comparators
  assign vsync_start_hi_out  = {overflow_reg_ff[OV_VSS9], overflow_reg_ff[OV_VSS8]};
  assign vdisplay_end_hi_out = {overflow_reg_ff[OV_VDE9], overflow_reg_ff[OV_VDE8]};
  assign vblank_start_hi_out = {cell_height_ext_in[0], overflow_reg_ff[OV_VBS8]};
  assign line_compare_hi_out = {cell_height_ext_in[1], overflow_reg_ff[OV_LC8]};

  // scroll settings; row scan is meant to change only in retrace
  assign pan_bytes_out       = row_scan_pan_reg_ff[PAN_LSB +: 2];
  assign pan_pixels_out      = {row_scan_pan_reg_ff[PAN_LSB +: 2], 3'h0};
  assign preset_row_scan_out = row_scan_pan_reg_ff[4:0];
  assign char_count_out      = char_cnt_ff;
  assign scanline_count_out  = line_cnt_ff;

  // assertions
  property p_sync_start;
    @(posedge clk_in) disable iff (rst_in)
      (hs_state_ff == HS_IDLE && hs_start_hit) |=> hs_pipe_ff[0];
  endproperty
  a_sync_start: assert property (p_sync_start) else $error("sync did not start");

  property p_sync_delay;
    @(posedge clk_in) disable iff (rst_in)
      (hsync_end_reg_ff[6:5] == 2'h2 && $stable(hsync_end_reg_ff))
        |-> hsync_out == $past(hs_pipe_ff[0], 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");

  property p_sync_end;
    @(posedge clk_in) disable iff (rst_in)
      (hs_state_ff == HS_PULSE && hs_end_hit) |=> hs_state_ff == HS_IDLE;
  endproperty
  a_sync_end: assert property (p_sync_end) else $error("sync did not end");

  property p_hblank;
    @(posedge clk_in) disable iff (rst_in)
      hblank_end_match_out |-> char_cnt_ff[5] == hsync_end_reg_ff[7];
  endproperty
  a_hblank: assert property (p_hblank) else $error("blank end bit 5 wrong");

  property p_retrace;
    @(posedge clk_in) disable iff (rst_in)
      vretrace_start_out |=> in_retrace_ff || $past(vretrace_end_in);
  endproperty
  a_retrace: assert property (p_retrace) else $error("retrace not entered");

  property p_protect;
    @(posedge clk_in) disable iff (rst_in)
      (reg_write_in && timing_write_protect_in && reg_index_in == IDX_VTOTAL)
        |=> $stable(vertical_total_reg_ff);
  endproperty
  a_protect: assert property (p_protect) else $error("protected write landed");

  property p_lc8;
    @(posedge clk_in) disable iff (rst_in)
      (reg_write_in && reg_index_in == IDX_OVERFLOW)
        |=> overflow_reg_ff[4] == $past(reg_wdata_in[4]);
  endproperty
  a_lc8: assert property (p_lc8) else $error("line compare 8 not written");

  property p_wrap;
    @(posedge clk_in) disable iff (rst_in)
      char_wrap && !vretrace_end_in |=> line_cnt_ff == $past(line_cnt_ff) + 10'h1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("scanline did not step");

  property p_pan;
    @(posedge clk_in) disable iff (rst_in)
      pan_pixels_out == 5'(pan_bytes_out * PIX_PER_BYTE);
  endproperty
  a_pan: assert property (p_pan) else $error("pan pixels wrong");

  // counter returns to zero on the edge that sees the programmed total
  property p_char_wrap;
    @(posedge clk_in) disable iff (rst_in)
      (char_cnt_ff[7:0] == horizontal_total_in) |=> char_cnt_ff == '0;
  endproperty
  a_char_wrap: assert property (p_char_wrap) else $error("counter did not wrap");

  // between wraps the counter steps by exactly one per character clock
  property p_char_step;
    @(posedge clk_in) disable iff (rst_in)
      (char_cnt_ff[7:0] != horizontal_total_in) |=> char_cnt_ff == $past(char_cnt_ff) + 1'b1;
  endproperty
  a_char_step: assert property (p_char_step) else $error("counter did not step");

  // retrace start tracks a total rebuilt here from the raw register bits
  property p_vtotal_hit;
    @(posedge clk_in) disable iff (rst_in)
      (line_cnt_ff == {overflow_reg_ff[OV_VT9], overflow_reg_ff[OV_VT8], vertical_total_reg_ff})
        && !in_retrace_ff && !vretrace_end_in |-> vretrace_start_out;
  endproperty
  a_vtotal_hit: assert property (p_vtotal_hit) else $error("retrace missed total");

  // vertical sync and display end high bits follow an unprotected write
  property p_vert_hi;
    @(posedge clk_in) disable iff (rst_in)
      (reg_write_in && reg_index_in == IDX_OVERFLOW && !timing_write_protect_in)
        |=> vsync_start_hi_out == {$past(reg_wdata_in[OV_VSS9]), $past(reg_wdata_in[OV_VSS8])}
         && vdisplay_end_hi_out == {$past(reg_wdata_in[OV_VDE9]), $past(reg_wdata_in[OV_VDE8])};
  endproperty
  a_vert_hi: assert property (p_vert_hi) else $error("high bits wrong");

  // blanking start and line compare take bit 8 here, bit 9 from the cell height
  property p_vert_ext;
    @(posedge clk_in) disable iff (rst_in)
      (reg_write_in && reg_index_in == IDX_OVERFLOW && !timing_write_protect_in)
        |=> vblank_start_hi_out == {cell_height_ext_in[0], $past(reg_wdata_in[OV_VBS8])}
         && line_compare_hi_out == {cell_height_ext_in[1], $past(reg_wdata_in[OV_LC8])};
  endproperty
  a_vert_ext: assert property (p_vert_ext) else $error("extension bits wrong");

  // protected writes leave both horizontal sync registers untouched
  property p_protect_h;
    @(posedge clk_in) disable iff (rst_in)
      (reg_write_in && timing_write_protect_in
        && (reg_index_in == IDX_HSYNC_START || reg_index_in == IDX_HSYNC_END))
        |=> $stable(hsync_start_reg_ff) && $stable(hsync_end_reg_ff);
  endproperty
  a_protect_h: assert property (p_protect_h) else $error("sync write landed");

  // under protection every overflow bit except line compare 8 holds
  property p_protect_ov;
    @(posedge clk_in) disable iff (rst_in)
      (reg_write_in && timing_write_protect_in && reg_index_in == IDX_OVERFLOW)
        |=> $stable({overflow_reg_ff[7:5], overflow_reg_ff[3:0]});
  endproperty
  a_protect_ov: assert property (p_protect_ov) else $error("overflow write landed");

  // an unprotected write is visible on the very next clock
  property p_write_now;
    @(posedge clk_in) disable iff (rst_in)
      (reg_write_in && reg_index_in == IDX_HSYNC_START && !timing_write_protect_in)
        |=> hsync_start_reg_ff == $past(reg_wdata_in);
  endproperty
  a_write_now: assert property (p_write_now) else $error("write not visible");

  // scroll outputs follow the row scan and pan register
  property p_row_scan;
    @(posedge clk_in) disable iff (rst_in)
      (reg_write_in && reg_index_in == IDX_ROW_SCAN_PAN)
        |=> preset_row_scan_out == $past(reg_wdata_in[4:0])
         && pan_bytes_out == $past(reg_wdata_in[PAN_LSB +: 2]);
  endproperty
  a_row_scan: assert property (p_row_scan) else $error("scroll fields wrong");

  // longest delay: the pin lags the internal state by three clocks
  property p_sync_delay3;
    @(posedge clk_in) disable iff (rst_in)
      (hsync_end_reg_ff[HDLY_LSB +: 2] == 2'h3) |-> hsync_out == $past(hs_pipe_ff[0], 3);
  endproperty
  a_sync_delay3: assert property (p_sync_delay3) else $error("sync delay 3 wrong");

  c_sync: cover property (@(posedge clk_in) disable iff (rst_in) $rose(hsync_out));
  c_retrace: cover property (@(posedge clk_in) disable iff (rst_in) vretrace_start_out);
  c_prot: cover property (@(posedge clk_in) disable iff (rst_in)
    reg_write_in && timing_write_protect_in && reg_index_in == IDX_OVERFLOW);
  c_delay: cover property (@(posedge clk_in) disable iff (rst_in)
    $rose(hsync_out) && hsync_end_reg_ff[HDLY_LSB +: 2] == 2'h3);
  c_hblank: cover property (@(posedge clk_in) disable iff (rst_in) hblank_end_match_out);
endmodule

// file: testbench/display_model.sv
// display end of the sync line: times each horizontal sync pulse it receives
module display_model (
  // character clock
  input  wire logic       clk_in,
  // sync seen at the connector, with the counter for position
  input  wire logic       hsync_in,
  input  wire logic [7:0] char_count_in,
  // measurements of the last complete pulse
  output int              pulses_out,
  output logic [7:0]      rise_at_out,
  output int              width_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int         run = 0;
  int         pulses = 0;
  int         width = 0;
  logic       prev = 1'b0;
  logic [7:0] rise_at = 8'h00;
  // one driver per output: the measuring process owns the variables
  assign pulses_out  = pulses;
  assign rise_at_out = rise_at;
  assign width_out   = width;
  // every falling edge counts, so a pulse cut by a reprogramming shows up as a bad width
  always @(posedge clk_in) begin
    prev <= hsync_in;
    if (hsync_in && !prev) begin
      rise_at <= char_count_in;
      run <= 1;
    end else if (hsync_in) begin
      run <= run + 1;
    end
    if (!hsync_in && prev) begin
      width <= run;
      pulses <= pulses + 1;
    end
  end
endmodule

// file: testbench/tb.sv
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import crtc_timing_pkg::*;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic [7:0] idx = 8'h00, wdat = 8'h00, htot = 8'd40, rdat, ccnt, r0, rise;
  logic       we = 1'b0, wp = 1'b0, vend = 1'b0, hsync, hbm, vrs;
  logic [4:0] hbe = 5'h00, ppix, prs;
  logic [1:0] chx = 2'b00, vsh, vdh, vbh, lch, pbytes;
  logic [9:0] scnt;
  int         n_fail = 0, num_checks = 0, pulses, width;
  crtc_hsync_vtotal_timing uut (.clk_in(clk_in), .rst_in(rst_in), .reg_index_in(idx),
    .reg_wdata_in(wdat), .reg_write_in(we), .reg_rdata_out(rdat), .horizontal_total_in(htot),
    .hblank_end_in(hbe), .cell_height_ext_in(chx), .timing_write_protect_in(wp),
    .vretrace_end_in(vend), .hsync_out(hsync), .hblank_end_match_out(hbm),
    .vretrace_start_out(vrs), .char_count_out(ccnt), .scanline_count_out(scnt),
    .vsync_start_hi_out(vsh), .vdisplay_end_hi_out(vdh), .vblank_start_hi_out(vbh),
    .line_compare_hi_out(lch), .pan_bytes_out(pbytes), .pan_pixels_out(ppix),
    .preset_row_scan_out(prs));
  display_model dm (.clk_in(clk_in), .hsync_in(hsync), .char_count_in(ccnt),
    .pulses_out(pulses), .rise_at_out(rise), .width_out(width));
  always #2.5 clk_in = ~clk_in;
  // one write strobe per call, launched and dropped on falling edges
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk_in);
    idx = i;
    wdat = d;
    we = 1'b1;
    @(negedge clk_in);
    we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    @(negedge clk_in);
    idx = i;
    #1;
    `CHK(rdat, e)
  endtask
  // the partner needs a fresh whole pulse after each change, so skip one
  task automatic two_pulses();
    int p;
    p = pulses;
    repeat (400) begin
      @(posedge clk_in);
      if (pulses >= p + 2) break;
    end
    if (pulses < p + 2) n_fail++;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    // reset values, plus an unmapped index that reads zero
    for (int i = 4; i <= 9; i++) rd(i[7:0], 8'h00);
    $display("test reset done");
    for (int i = 4; i <= 8; i++) begin
      wr(i[7:0], 8'hff);
      rd(i[7:0], (i == 8) ? ROW_SCAN_PAN_MASK : 8'hff);
    end
    wr(IDX_OVERFLOW, 8'h00);
    wr(IDX_HSYNC_START, 8'h11);
    wp = 1'b1;
    wr(IDX_HSYNC_START, 8'h22);
    rd(IDX_HSYNC_START, 8'h11);
    wr(IDX_OVERFLOW, 8'hff);
    rd(IDX_OVERFLOW, 8'h10);
    wr(IDX_VTOTAL, 8'h33);
    rd(IDX_VTOTAL, 8'hff);
    wr(IDX_HSYNC_END, 8'h33);
    rd(IDX_HSYNC_END, 8'hff);
    wp = 1'b0;
    $display("test protect done");
    // overflow bits routed onto the widened vertical fields
    for (int k = 0; k < 2; k++) begin
      chx = k ? 2'b10 : 2'b01;
      wr(IDX_OVERFLOW, k ? 8'h5a : 8'ha5);
      `CHK(vsh, {wdat[7], wdat[2]})
      `CHK(vdh, {wdat[6], wdat[1]})
      `CHK(vbh, {chx[0], wdat[3]})
      `CHK(lch, {chx[1], wdat[4]})
    end
    for (int c = 0; c < 4; c++) begin
      wr(IDX_ROW_SCAN_PAN, {1'b0, c[1:0], 5'(c * 7)});
      `CHK(pbytes, c[1:0])
      `CHK(ppix, 5'(c * PIX_PER_BYTE))
      `CHK(prs, 5'(c * 7))
    end
    $display("test fields done");
    // start 20 of total 40, width 5: at least four clocks to total, inside blanking
    wr(IDX_HSYNC_START, 8'd20);
    for (int d = 0; d < 4; d++) begin
      wr(IDX_HSYNC_END, {1'b0, d[1:0], 5'd25});
      two_pulses();
      if (d == 0) r0 = rise;
      `CHK(rise, r0 + 8'(d))
      `CHK(width, 5)
    end
    // the sync state is registered, so the pin shows one clock after the start match
    `CHK(r0, 8'd21)
    wr(IDX_HSYNC_START, 8'd23);
    wr(IDX_HSYNC_END, 8'd28);
    two_pulses();
    `CHK(rise, r0 + 8'd3)
    `CHK(width, 5)
    $display("test hsync done");
    @(negedge clk_in);
    htot = 8'd63;
    hbe = 5'h0a;
    wr(IDX_HSYNC_END, 8'h80);
    repeat (200) begin
      @(negedge clk_in);
      if (ccnt[5:0] == 6'h2a) `CHK(hbm, 1'b1)
      if (ccnt[5:0] == 6'h0a) `CHK(hbm, 1'b0)
      if (ccnt > htot) `CHK(ccnt, htot)
    end
    $display("test hblank done");
    // vertical total of 3 starts retrace when the scanline counter reaches 3
    wr(IDX_VTOTAL, 8'h03);
    wr(IDX_OVERFLOW, 8'h00);
    vend = 1'b1;
    @(negedge clk_in);
    vend = 1'b0;
    repeat (1000) begin
      @(negedge clk_in);
      if (vrs === 1'b1) break;
    end
    `CHK(vrs, 1'b1)
    `CHK(scnt, 10'h003)
    wr(IDX_ROW_SCAN_PAN, 8'h04);
    `CHK(prs, 5'h04)
    $display("test vtotal done");
    give_verdict();
  end
endmodule
